// File: src/rst_seq_pkg.sv
/*
 * Constants and types shared by the reset and initialization sequencer:
 * register map, power-on values of the architectural registers, delay
 * counts and the state encoding.
 * Assumes a single 25 MHz clock domain.
 */
package rst_seq_pkg;

   // Clock period in ns, used to relate cycle figures to time
   localparam int unsigned CLK_PERIOD_NS = 40;

   // Post-release delay per core clock multiplier, in external clocks
   localparam logic [7:0] WAIT_CYC_2X0 = 8'h96;   // 150 cycles
   localparam logic [7:0] WAIT_CYC_2X5 = 8'hB8;   // 184 cycles
   localparam logic [7:0] WAIT_CYC_3X0 = 8'hD9;   // 217 cycles
   localparam logic [7:0] WAIT_CYC_3X5 = 8'hFA;   // 250 cycles
   // Same delays, indexed by the multiplier strap code
   localparam logic [7:0] WAIT_TAB [4] = '{WAIT_CYC_2X0, WAIT_CYC_2X5,
                                           WAIT_CYC_3X0, WAIT_CYC_3X5};

   // Extra self-test time, 2^20 external clocks
   localparam int unsigned SELFTEST_CYC_DFLT = 32'h0010_0000;
   localparam int unsigned CNT_W             = 21;

   // Multiplier strap encodings
   localparam logic [1:0] MULT_2X0 = 2'h0;
   localparam logic [1:0] MULT_2X5 = 2'h1;
   localparam logic [1:0] MULT_3X0 = 2'h2;
   localparam logic [1:0] MULT_3X5 = 2'h3;

   // Power-on values of the architectural registers
   localparam logic [31:0] RESET_VECTOR   = 32'hFFFF_FFF0;
   localparam logic [31:0] IP_INIT        = 32'h0000_FFF0;
   localparam logic [31:0] FLAGS_INIT     = 32'h0000_0002;
   localparam logic [31:0] ACC_PASS       = 32'h0000_0000;
   localparam logic [31:0] ACC_NOT_PASSED = 32'hFFFF_FFFF;
   localparam logic [15:0] CS_SEL_INIT    = 16'hF000;
   localparam logic [31:0] CS_BASE_INIT   = 32'hFFFF_0000;
   localparam logic [15:0] DSEG_SEL_INIT  = 16'h0000;
   localparam logic [31:0] DSEG_BASE_INIT = 32'h0000_0000;
   localparam logic [15:0] SEG_LIM_INIT   = 16'hFFFF;
   localparam logic [31:0] IDT_BASE_INIT  = 32'h0000_0000;
   localparam logic [15:0] IDT_LIM_INIT   = 16'h03FF;

   // Register map, byte addresses
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_ACC      = 8'h08;
   localparam logic [7:0] OFS_DATA_ID  = 8'h0C;
   localparam logic [7:0] OFS_FLAGS    = 8'h10;
   localparam logic [7:0] OFS_IP       = 8'h14;
   localparam logic [7:0] OFS_CS_SEL   = 8'h18;
   localparam logic [7:0] OFS_CS_BASE  = 8'h1C;
   localparam logic [7:0] OFS_DS_SEL   = 8'h20;
   localparam logic [7:0] OFS_ES_SEL   = 8'h24;
   localparam logic [7:0] OFS_SS_SEL   = 8'h28;
   localparam logic [7:0] OFS_DSEG_BSE = 8'h2C;
   localparam logic [7:0] OFS_SEG_LIM  = 8'h30;
   localparam logic [7:0] OFS_IDT_BASE = 8'h34;
   localparam logic [7:0] OFS_IDT_LIM  = 8'h38;

   // Control register field positions
   localparam int unsigned CTRL_CACHE_EN = 0;
   localparam int unsigned CTRL_PAGE_EN  = 1;
   localparam int unsigned CTRL_PROT     = 2;
   localparam logic [2:0]  CTRL_INIT     = 3'h0;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_HOLD  = 3'b000,   // reset pin asserted
      ST_BIST  = 3'b001,   // self-test running
      ST_WAIT  = 3'b010,   // post-release delay
      ST_RUN   = 3'b011    // fetching and executing
   } seq_state_type;

   // Segment register with its hidden part
   typedef struct packed {
      logic [15:0] sel;
      logic [31:0] base;
      logic [15:0] limit;
   } seg_type;

   // Descriptor table register
   typedef struct packed {
      logic [31:0] base;
      logic [15:0] limit;
   } table_type;

endpackage : rst_seq_pkg

// File: src/level_sync.sv
/*
 * Two flip-flop level synchronizer, parameterised in width.
 * Assumes the destination clock is clk_i; first stage feeds only the second.
 */
`timescale 1ns/1ps
module level_sync #(
   parameter int unsigned      WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT  = '1   // Level held through reset
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   // Level in and out
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta;   // First stage, read only by q_o

   // Both stages come up at the constant init value
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta <= INIT;
         q_o  <= INIT;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule : level_sync

// File: src/cpu_reset_init.sv
/*
 * Reset and initialization sequencer of the processor core: holds the
 * core while the reset pin is asserted, loads power-on register values,
 * runs the optional self-test delay and starts the first fetch.
 * Assumes synchronous pins on clk_i and a simple strobe register port.
 */
`timescale 1ns/1ps
// Operation
// - Reset forces real mode, loads power-on values
// - Reset invalidates cache, disables cache and paging
// - Reset abandons bus cycle, stops execution immediately; code does both on the third clock after the pin
// - While held: pipelines flushed, no execution, no bus
// - Fetch FFFF_FFF0 150-250 clocks after release; code fetches 153-253 clocks after the pin
// - Self-test adds 2^20 clocks before fetch
// - Accumulator zero when self-test ran and passed
// - Data register holds family and multiplier ident
// - Code segment F000, base FFFF0000, IP FFF0
// - Extra, stack, data segments zero, limit FFFF
// - Interrupt table base zero, limit 3FF
module cpu_reset_init
   import rst_seq_pkg::*;
#(
   parameter int unsigned SELFTEST_CYC = SELFTEST_CYC_DFLT,
   parameter logic [7:0]  FAMILY_CODE  = 8'hA5,  // Arbitrary value
   parameter logic [7:0]  ID_2X0       = 8'h11,  // Arbitrary value
   parameter logic [7:0]  ID_2X5       = 8'h12,  // Arbitrary value
   parameter logic [7:0]  ID_3X0       = 8'h13,  // Arbitrary value
   parameter logic [7:0]  ID_3X5       = 8'h14   // Arbitrary value
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // Reset pin and straps
   input  wire logic        cpu_reset_i,
   input  wire logic        selftest_req_i,
   input  wire logic [1:0]  mult_sel_i,
   input  wire logic        selftest_ok_i,
   // Register port
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wr_data_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rd_data_o,
   // Core control
   output logic             core_halt_o,
   output logic             bus_abort_o,
   output logic             pipe_flush_o,
   output logic             cache_inval_o,
   output logic             cache_enable_o,
   output logic             paging_enable_o,
   output logic             real_mode_o,
   output logic             core_run_o,
   output logic             fetch_start_o,
   output logic      [31:0] fetch_addr_o
);

   seq_state_type    state;         // Sequencer state
   logic             rst_sync;      // Synchronized reset pin
   logic             rst_prev;      // For assertion edge
   logic [CNT_W-1:0] cnt;           // Delay down-counter
   logic [1:0]       mult;          // Captured multiplier strap
   logic             bist_sel;      // Captured self-test strap
   logic             bist_ran;      // Self-test completed
   logic             bist_ok;       // Self-test result
   logic [2:0]       ctrl;          // Software control bits
   logic [31:0]      accumulator_reg;
   logic [31:0]      data_reg_with_ident;
   logic [31:0]      flags_word;
   logic [31:0]      instruction_pointer;
   seg_type          code_segment;
   seg_type          data_segment;
   seg_type          extra_segment;
   seg_type          stack_segment;
   table_type        interrupt_table_descriptor;
   logic [7:0]       wait_len;      // Delay for captured multiplier
   logic [7:0]       ident;         // Ident for captured multiplier
   logic [31:0]      next_rd_data;  // Read mux

   // Pin is synchronous but may glitch at power up; two stages anyway
   level_sync #(.WIDTH(1), .INIT(1'b1)) u_rst_sync (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .d_i    (cpu_reset_i),
      .q_o    (rst_sync)
   );

   // Delay and ident for the strapped multiplier, indexed by its code
   localparam logic [7:0] ID_TAB [4] = '{ID_2X0, ID_2X5, ID_3X0, ID_3X5};
   assign wait_len = WAIT_TAB[mult];
   assign ident    = ID_TAB[mult];

   // Straps are caught by the clock while the pin is held
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mult     <= MULT_2X0;
         bist_sel <= 1'b0;
      end else if (rst_sync) begin
         mult     <= mult_sel_i;
         bist_sel <= selftest_req_i;
      end
   end

   // Sequencer: hold, optional self-test, delay, run
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= ST_HOLD;
         cnt   <= '0;
      end else if (rst_sync) begin
         state <= ST_HOLD;
         cnt   <= '0;
      end else begin
         unique case (state)
            ST_HOLD: begin
               // Self-test comes first, then the ordinary delay
               if (bist_sel) begin
                  state <= ST_BIST;
                  cnt   <= CNT_W'(SELFTEST_CYC - 1);
               end else begin
                  state <= ST_WAIT;
                  cnt   <= CNT_W'(wait_len - 8'h01);
               end
            end
            ST_BIST: begin
               if (cnt == '0) begin
                  state <= ST_WAIT;
                  cnt   <= CNT_W'(wait_len - 8'h01);
               end else begin
                  cnt <= cnt - CNT_W'(1);
               end
            end
            ST_WAIT: begin
               if (cnt == '0) begin
                  state <= ST_RUN;
               end else begin
                  cnt <= cnt - CNT_W'(1);
               end
            end
            ST_RUN:  state <= ST_RUN;
            default: state <= ST_HOLD;
         endcase
      end
   end

   // Self-test result, sampled when the test time ends
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bist_ran <= 1'b0;
         bist_ok  <= 1'b0;
      end else if (rst_sync) begin
         bist_ran <= 1'b0;
         bist_ok  <= 1'b0;
      end else if (state == ST_BIST && cnt == '0) begin
         bist_ran <= 1'b1;
         bist_ok  <= selftest_ok_i;
      end
   end

   // Core control outputs, all registered
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         core_halt_o   <= 1'b1;
         bus_abort_o   <= 1'b0;
         pipe_flush_o  <= 1'b1;
         cache_inval_o <= 1'b1;
         core_run_o    <= 1'b0;
         fetch_start_o <= 1'b0;
         fetch_addr_o  <= RESET_VECTOR;
      end else begin
         // Abort pulse marks the first held cycle only
         bus_abort_o   <= rst_sync && state != ST_HOLD;
         core_halt_o   <= rst_sync || state != ST_RUN;
         pipe_flush_o  <= rst_sync;
         cache_inval_o <= rst_sync;
         core_run_o    <= !rst_sync && state == ST_RUN;
         fetch_start_o <= !rst_sync && state == ST_WAIT && cnt == '0;
         fetch_addr_o  <= RESET_VECTOR;
      end
   end

   // Control bits; cleared while held, writable only when running
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl <= CTRL_INIT;
      end else if (rst_sync) begin
         ctrl <= CTRL_INIT;
      end else if (wr_i && addr_i == OFS_CTRL && state == ST_RUN) begin
         ctrl <= wr_data_i[2:0];
      end
   end

   // Mode outputs follow the control bits
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cache_enable_o  <= 1'b0;
         paging_enable_o <= 1'b0;
         real_mode_o     <= 1'b1;
      end else begin
         cache_enable_o  <= ctrl[CTRL_CACHE_EN] && !rst_sync;
         paging_enable_o <= ctrl[CTRL_PAGE_EN] && !rst_sync;
         real_mode_o     <= !ctrl[CTRL_PROT] || rst_sync;
      end
   end

   // Architectural registers take power-on values while held; the
   // synchronizer comes up asserted, so no async branch is needed
   always_ff @(posedge clk_i) begin
      if (rst_sync) begin
         flags_word          <= FLAGS_INIT;
         instruction_pointer <= IP_INIT;
         code_segment        <= '{CS_SEL_INIT, CS_BASE_INIT, SEG_LIM_INIT};
         data_segment  <= '{DSEG_SEL_INIT, DSEG_BASE_INIT, SEG_LIM_INIT};
         extra_segment <= '{DSEG_SEL_INIT, DSEG_BASE_INIT, SEG_LIM_INIT};
         stack_segment <= '{DSEG_SEL_INIT, DSEG_BASE_INIT, SEG_LIM_INIT};
         interrupt_table_descriptor <= '{IDT_BASE_INIT, IDT_LIM_INIT};
      end
   end

   // Accumulator and data register settle as the sequence proceeds
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         accumulator_reg     <= ACC_NOT_PASSED;
         data_reg_with_ident <= 32'h0000_0000;
      end else if (rst_sync) begin
         // Undefined unless self-test passes; a fixed pattern is cheaper
         accumulator_reg     <= ACC_NOT_PASSED;
         data_reg_with_ident <= {16'h0000, FAMILY_CODE, ident};
      end else if (state == ST_BIST && cnt == '0) begin
         accumulator_reg <= selftest_ok_i ? ACC_PASS
                                          : ACC_NOT_PASSED;
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb begin
      next_rd_data = 32'h0000_0000;
      unique case (addr_i)
         OFS_CTRL:     next_rd_data = {29'h0000_0000, ctrl};
         OFS_STATUS:   next_rd_data = {25'h000_0000, state, bist_ran,
                                       bist_ok, mult};
         OFS_ACC:      next_rd_data = accumulator_reg;
         OFS_DATA_ID:  next_rd_data = data_reg_with_ident;
         OFS_FLAGS:    next_rd_data = flags_word;
         OFS_IP:       next_rd_data = instruction_pointer;
         OFS_CS_SEL:   next_rd_data = {16'h0000, code_segment.sel};
         OFS_CS_BASE:  next_rd_data = code_segment.base;
         OFS_DS_SEL:   next_rd_data = {16'h0000, data_segment.sel};
         OFS_ES_SEL:   next_rd_data = {16'h0000, extra_segment.sel};
         OFS_SS_SEL:   next_rd_data = {16'h0000, stack_segment.sel};
         OFS_DSEG_BSE: next_rd_data = data_segment.base;
         OFS_SEG_LIM:  next_rd_data = {16'h0000, code_segment.limit};
         OFS_IDT_BASE: next_rd_data = interrupt_table_descriptor.base;
         OFS_IDT_LIM:  next_rd_data = {16'h0000,
                                       interrupt_table_descriptor.limit};
         default:      next_rd_data = 32'h0000_0000;
      endcase
   end

   // Read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_data_o <= 32'h0000_0000;
      end else begin
         rd_data_o <= rd_i ? next_rd_data : 32'h0000_0000;
      end
   end

   // Helper for checks: clocks since the synchronized release
   logic [CNT_W:0] rel_cnt;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rel_cnt  <= '0;
         rst_prev <= 1'b1;
      end else begin
         rst_prev <= rst_sync;
         rel_cnt  <= rst_sync ? '0 : rel_cnt + (CNT_W+1)'(1);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   sequence seq_enter_hold;
      !rst_prev && rst_sync;
   endsequence

   sequence seq_release;
      rst_sync ##1 !rst_sync;
   endsequence

   chk_hold_quiet: assert property (
      rst_sync |=> core_halt_o && pipe_flush_o && !core_run_o
      && !fetch_start_o) else $error("core not quiet while reset held");
   chk_abort_pulse: assert property (
      seq_enter_hold |=> bus_abort_o ##1 !bus_abort_o)
      else $error("bus abort not a single pulse on reset entry");
   chk_cache_off: assert property (
      rst_sync |=> cache_inval_o && !cache_enable_o && !paging_enable_o
      && real_mode_o) else $error("cache or paging on while reset held");
   chk_no_early_fetch: assert property (
      seq_release |-> !fetch_start_o [*8])
      else $error("fetch started right after release");
   chk_wait_len: assert property (
      fetch_start_o && !bist_ran |-> rel_cnt == (CNT_W+1)'(wait_len)
      + (CNT_W+1)'(1)) else $error("post-release delay wrong");
   chk_bist_len: assert property (
      fetch_start_o && bist_ran |-> rel_cnt == (CNT_W+1)'(wait_len)
      + (CNT_W+1)'(SELFTEST_CYC) + (CNT_W+1)'(1))
      else $error("self-test delay wrong");
   chk_fetch_vector: assert property (
      fetch_start_o |-> fetch_addr_o == RESET_VECTOR ##1 core_run_o)
      else $error("first fetch not at reset vector");
   chk_acc_pass: assert property (
      fetch_start_o && bist_ran && bist_ok |-> accumulator_reg == ACC_PASS)
      else $error("accumulator not zero after passed self-test");
   chk_ident_code: assert property (
      seq_release |-> data_reg_with_ident == {16'h0000, FAMILY_CODE, ident})
      else $error("ident code wrong");
   chk_seg_init: assert property (
      rst_sync |=> code_segment.sel == CS_SEL_INIT
      && code_segment.base == CS_BASE_INIT && instruction_pointer == IP_INIT
      && data_segment.sel == DSEG_SEL_INIT
      && extra_segment.sel == DSEG_SEL_INIT
      && stack_segment.limit == SEG_LIM_INIT)
      else $error("segment power-on values wrong");
   chk_table_flags: assert property (
      rst_sync |=> flags_word == FLAGS_INIT
      && interrupt_table_descriptor.limit == IDT_LIM_INIT)
      else $error("flags or interrupt table power-on values wrong");

endmodule : cpu_reset_init

// File: testbench/sys_reset_src.sv
/*
 * Board reset source: drives the reset pin and the straps.
 * Assumes the bench commands it on clk_i with non-blocking assignments.
 */
`timescale 1ns/1ps
module sys_reset_src (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // Commands from the bench
   input  wire logic       hold_i,
   input  wire logic       st_i,
   input  wire logic       ok_i,
   input  wire logic [1:0] mult_i,
   // Pin and straps
   output logic            cpu_reset_o,
   output logic            selftest_req_o,
   output logic            selftest_ok_o,
   output logic      [1:0] mult_sel_o
);
   // Pin follows the command at once
   assign cpu_reset_o = hold_i;
   // Straps only move while the pin is held, so they never glitch in run
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         selftest_req_o <= 1'b0;
         selftest_ok_o  <= 1'b0;
         mult_sel_o     <= 2'h0;
      end else if (hold_i) begin
         selftest_req_o <= st_i;
         selftest_ok_o  <= ok_i;
         mult_sel_o     <= mult_i;
      end
   end
endmodule : sys_reset_src

// File: testbench/cpu_reset_initialization_tb_top.sv
/*
 * Self-checking bench for the reset sequencer: every multiplier, with and
 * without self-test, power-on register values, reassertion mid-run.
 * Assumes SELFTEST_CYC is shortened to 16 and a 25 MHz clock.
 */
`timescale 1ns/1ps
module cpu_reset_initialization_tb_top;
   import rst_seq_pkg::*;
   localparam int ST_CYC    = 16;     // Shortened self-test length
   localparam int CYC_LIMIT = 20000;  // Ceiling well above 8 runs
   logic        clk_i = 0, nrst_i = 0;  // Clock and async reset
   logic        hold = 1, st = 0, ok = 0;  // Partner commands
   logic [1:0]  mult = 2'h0;
   logic        cpu_reset, st_req, st_ok;  // Pin and straps
   logic [1:0]  mult_sel;
   logic [7:0]  addr_i = 8'h00;       // Register port
   logic [31:0] wr_data_i = 32'h0000_0000, rd_data_o;
   logic        wr_i = 0, rd_i = 0;
   logic        halt, abort, flush, inval, cen, pen, rmode, run, fstart;
   logic [31:0] faddr;
   int          err_count = 0, total_checks = 0, cyc_count = 0, n;
   logic [7:0]  lfsr = 8'h61;         // Random source, starts at 97
   logic [31:0] acc_exp;
   logic [7:0]  ofs [12] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24,
                             8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
   logic [31:0] val [12] = '{32'h0000_0002, 32'h0000_FFF0, 32'h0000_F000,
                             32'hFFFF_0000, 32'h0, 32'h0, 32'h0, 32'h0,
                             32'h0000_FFFF, 32'h0, 32'h0000_03FF, 32'h0};
   int          wait_cyc [4] = '{150, 184, 217, 250};
   logic [7:0]  id_of [4] = '{8'h11, 8'h12, 8'h13, 8'h14};

   always #20 clk_i = ~clk_i;  // 40 ns period

   sys_reset_src i_sys_reset_src (.clk_i(clk_i), .nrst_i(nrst_i),
      .hold_i(hold), .st_i(st), .ok_i(ok), .mult_i(mult),
      .cpu_reset_o(cpu_reset), .selftest_req_o(st_req),
      .selftest_ok_o(st_ok), .mult_sel_o(mult_sel));

   cpu_reset_init #(.SELFTEST_CYC(ST_CYC)) i_cpu_reset_init (
      .clk_i(clk_i), .nrst_i(nrst_i), .cpu_reset_i(cpu_reset),
      .selftest_req_i(st_req), .mult_sel_i(mult_sel),
      .selftest_ok_i(st_ok), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
      .core_halt_o(halt), .bus_abort_o(abort), .pipe_flush_o(flush),
      .cache_inval_o(inval), .cache_enable_o(cen),
      .paging_enable_o(pen), .real_mode_o(rmode), .core_run_o(run),
      .fetch_start_o(fstart), .fetch_addr_o(faddr));

   // Eight-bit Galois LFSR step
   function automatic logic [7:0] next_lfsr(input logic [7:0] s);
      next_lfsr = {s[6:0], 1'b0} ^ (s[7] ? 8'h1D : 8'h00);
   endfunction : next_lfsr

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   // One-cycle write strobe
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i    <= a;
      wr_data_i <= d;
      wr_i      <= 1'b1;
      @(posedge clk_i);
      wr_i      <= 1'b0;
   endtask : reg_wr

   // Read: data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 chk(rd_data_o, exp);
   endtask : reg_rd

   // Verdict and end of run
   task automatic wrap_up;
      if (err_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   // Hang guard
   always @(posedge clk_i) begin
      cyc_count++;
      if (cyc_count == CYC_LIMIT) begin
         err_count++;
         wrap_up();
      end
   end

   initial begin
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         lfsr = next_lfsr(lfsr);
         @(posedge clk_i);
         hold <= 1'b1;
         addr_i    <= lfsr;
         wr_data_i <= {4{lfsr}};
         mult <= k[1:0];
         st   <= k[2];
         ok   <= (k == 4) ? 1'b1 : lfsr[0];
         // Reassertion mid-run: abort pulse on the third edge only
         for (int e = 1; e <= 4; e++) begin
            @(posedge clk_i);
            #1;
            if (k > 0) chk({31'h0, abort}, {31'h0, e == 3});
         end
         chk({29'h0, cen, pen, rmode}, 32'h1);
         chk({27'h0, halt, flush, inval, run, fstart},
             32'h1C);
         reg_wr(8'h00, 32'h0000_0003);  // Ignored while held
         repeat (3) @(posedge clk_i);
         hold <= 1'b0;
         n = 0;
         do begin
            @(posedge clk_i);
            #1 n++;
            if (n < 3) chk({31'h0, halt}, 32'h1);
         end while (fstart !== 1'b1 && n < 1000);
         chk(n, wait_cyc[k%4] + 3 + (k[2] ? ST_CYC : 0));
         chk(faddr, 32'hFFFF_FFF0);
         @(posedge clk_i);
         #1 chk({27'h0, run, halt, fstart, cen, pen}, 32'h10);
         chk({29'h0, flush, inval, rmode}, 32'h1);
         acc_exp = (k[2] && ok) ? 32'h0 : 32'hFFFF_FFFF;
         reg_rd(8'h08, acc_exp);
         reg_rd(8'h0C, {16'h0, 8'hA5, id_of[k % 4]});
         reg_rd(8'h04, {25'h0, 3'h3, k[2], k[2] & ok, k[1:0]});
         for (int r = 0; r < 12; r++)
            reg_rd(ofs[r], val[r]);
         // Enable cache, paging and protection, next reset clears them
         reg_wr(8'h00, 32'h0000_0007);
         repeat (2) @(posedge clk_i);
         #1 chk({29'h0, cen, pen, rmode}, 32'h6);
      end
      wrap_up();
   end
endmodule : cpu_reset_initialization_tb_top
